// file: ufcaf_node_model.sv
// remote serial node model driving the receive shifter outputs
`timescale 1ns/1ps
`default_nettype none
module ufcaf_node_model (
	// clock
	input  wire logic mclk,
	// receive shifter side
	output logic       rx_last_data,
	output logic [7:0] rx_byte,
	output logic       rx_ninth_bit,
	output logic       rx_stop_strobe,
	output logic       rx_stop_level
);
	// quiet lines before the first frame
	initial begin
		rx_last_data = 1'b0;
		rx_byte = 8'h00;
		rx_ninth_bit = 1'b0;
		rx_stop_strobe = 1'b0;
		rx_stop_level = 1'b1;
	end
	// data part of a frame; stale lines show the inverse so nothing reads them by luck
	task automatic send_data(input logic [7:0] b, input logic n);
		@(posedge mclk);
		rx_byte <= b;
		rx_ninth_bit <= n;
		rx_last_data <= 1'b1;
		@(posedge mclk);
		rx_byte <= ~b;
		rx_ninth_bit <= ~n;
		rx_last_data <= 1'b0;
	endtask
	// stop bit sample, the level chosen by the bench (a low one is a bad frame)
	task automatic send_stop(input logic s);
		@(posedge mclk);
		rx_stop_level <= s;
		rx_stop_strobe <= 1'b1;
		@(posedge mclk);
		rx_stop_level <= ~s;
		rx_stop_strobe <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: ufcaf_pkg.sv
// constants for the frame check and address filter block
`default_nettype none
package ufcaf_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0]  SER_CTRL_IDX  = 8'h98;
	localparam logic [7:0]  PWR_CTRL_IDX  = 8'h87;
	localparam logic [7:0]  NODE_ADDR_IDX = 8'hA9;
	localparam logic [7:0]  NODE_MASK_IDX = 8'hB9;
	localparam int          REG_AW        = 12;
	localparam logic [11:0] SER_CTRL_ADDR  = {2'h0, SER_CTRL_IDX, 2'h0};
	localparam logic [11:0] PWR_CTRL_ADDR  = {2'h0, PWR_CTRL_IDX, 2'h0};
	localparam logic [11:0] NODE_ADDR_ADDR = {2'h0, NODE_ADDR_IDX, 2'h0};
	localparam logic [11:0] NODE_MASK_ADDR = {2'h0, NODE_MASK_IDX, 2'h0};
	localparam logic [11:0] IRQ_STAT_ADDR  = 12'h300;
	localparam logic [11:0] IRQ_MASK_ADDR  = 12'h304;
	localparam logic [11:0] RX_DATA_ADDR   = 12'h308;
	// serial control fields
	localparam int SC_FE_SM0 = 7;
	localparam int SC_SM1    = 6;
	localparam int SC_MPE    = 5;
	localparam int SC_REN    = 4;
	localparam int SC_TB8    = 3;
	localparam int SC_RB8    = 2;
	localparam int SC_TI     = 1;
	localparam int SC_RI     = 0;
	// power control fields
	localparam int PC_DBL    = 7;
	localparam int PC_FCE    = 6;
	// interrupt status fields
	localparam int IS_RX     = 0;
	localparam int IS_FE     = 1;
	localparam int IS_W      = 2;
	// reset values and bus responses
	localparam logic [7:0] SER_CTRL_RST  = 8'h00;
	localparam logic [7:0] NODE_ADDR_RST = 8'h00;
	localparam logic [7:0] NODE_MASK_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

// file: ufcaf_tb_top.sv
// self-checking bench for the frame check and address filter block
`timescale 1ns/1ps
`default_nettype none
module ufcaf_tb_top;
	// bus side stimulus and design outputs
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] awa = 12'h000;
	logic [11:0] ara = 12'h000;
	logic [31:0] wd = 32'h00000000;
	logic [3:0]  ws = 4'h0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        bry = 1'b0;
	logic        arv = 1'b0;
	logic        rry = 1'b0;
	wire logic   awr, wrd, bv, arr, rv, rld, rn, rss, rsl, ri, fe, irq;
	wire logic [1:0]  br, rr, smode;
	wire logic [31:0] rd;
	wire logic [7:0]  rb;
	// reference model state
	logic [31:0] v, x, st, seed = 32'h0001317F;
	logic [7:0]  na, mk, b, sc;
	logic [1:0]  m, im;
	logic        mpe, fce, n, s, ck, fl, dfr, ad, hit, acc, ri_m, fe_m, r8;
	logic [7:0]  q[$];
	int          it, f, cyc, n_errors, check_count;

	ufcaf_node_model node (.mclk(mclk), .rx_last_data(rld), .rx_byte(rb), .rx_ninth_bit(rn),
		.rx_stop_strobe(rss), .rx_stop_level(rsl));
	ufcaf_top dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .rx_last_data(rld),
		.rx_byte(rb), .rx_ninth_bit(rn), .rx_stop_strobe(rss), .rx_stop_level(rsl),
		.serial_mode(smode), .rx_enable(), .tx_ninth_bit(), .double_baud(),
		.receive_done_flag(ri), .framing_error_flag(fe), .irq(irq));

	// xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// wait edges, then step clear of the edge
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	// register write: address and data offered together, each released when taken
	task automatic wreg(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ga, gw;
		@(posedge mclk);
		awa <= a;
		awv <= 1'b1;
		wd <= {24'h000000, d};
		ws <= 4'hF;
		wv <= 1'b1;
		bry <= 1'b1;
		ga = 1'b0;
		gw = 1'b0;
		while (!ga || !gw) begin
			@(posedge mclk);
			if (awr && !ga) begin
				ga = 1'b1;
				awv <= 1'b0;
			end
			if (wrd && !gw) begin
				gw = 1'b1;
				wv <= 1'b0;
			end
		end
		while (!bv) @(posedge mclk);
		bry <= 1'b0;
		chk(32'(br), 32'(er));
	endtask
	// register read
	task automatic rreg(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge mclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge mclk); while (!arr);
		arv <= 1'b0;
		do @(posedge mclk); while (!rv);
		d = rd;
		rry <= 1'b0;
		chk(32'(rr), 32'(er));
	endtask
	// verdict
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			complete_run();
		end
	end
	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		tick(2);
		rreg(ufcaf_pkg::NODE_ADDR_ADDR, v, ufcaf_pkg::RESP_OKAY);
		chk(v, 32'h00000000);
		rreg(ufcaf_pkg::NODE_MASK_ADDR, v, ufcaf_pkg::RESP_OKAY);
		chk(v, 32'h00000000);
		rreg(12'h400, v, ufcaf_pkg::RESP_SLVERR);
		chk(v, 32'h00000000);
		wreg(12'h400, 8'h5A, ufcaf_pkg::RESP_SLVERR);
		ri_m = 1'b0;
		fe_m = 1'b0;
		st = 32'h00000000;
		for (it = 0; it < 60; it++) begin
			x = rnd();
			m = x[1:0];
			mpe = x[2];
			fce = x[3];
			na = x[15:8];
			mk = (x[5:4] == 2'h0) ? 8'hFF : x[23:16];
			im = x[7:6];
			sc = {m[1], m[0], mpe, 1'b1, 4'h0};
			r8 = 1'b0;
			wreg(ufcaf_pkg::PWR_CTRL_ADDR, 8'h00, ufcaf_pkg::RESP_OKAY);
			wreg(ufcaf_pkg::SER_CTRL_ADDR, sc, ufcaf_pkg::RESP_OKAY);
			wreg(ufcaf_pkg::PWR_CTRL_ADDR, {1'b0, fce, 6'h00}, ufcaf_pkg::RESP_OKAY);
			wreg(ufcaf_pkg::NODE_ADDR_ADDR, na, ufcaf_pkg::RESP_OKAY);
			wreg(ufcaf_pkg::NODE_MASK_ADDR, mk, ufcaf_pkg::RESP_OKAY);
			wreg(ufcaf_pkg::IRQ_MASK_ADDR, {6'h00, im}, ufcaf_pkg::RESP_OKAY);
			chk(32'(smode), 32'(m));
			// two frames, the second always with a good stop bit
			for (f = 0; f < 2; f++) begin
				x = rnd();
				b = (x[1:0] == 2'h0) ? na : (x[1:0] == 2'h1) ? (na | mk) : x[15:8];
				n = x[2];
				s = (f == 1) || (x[4:3] != 2'h0);
				ck = fce && (m != 2'h0);
				fl = mpe && (m != 2'h0);
				dfr = ck || (fl && m == 2'h1);
				ad = (m == 2'h1) ? s : n;
				hit = (((b ^ na) & mk) == 8'h00) || ((b & (na | mk)) == (na | mk));
				acc = !fl || (ad && hit);
				if (m == 2'h1) begin
					r8 = s;
				end else if (m != 2'h0 && acc) begin
					r8 = n;
				end
				node.send_data(b, n);
				tick(2);
				chk(32'(ri), 32'(ri_m | (acc & !dfr)));
				if (m != 2'h0) node.send_stop(s);
				tick(3);
				ri_m = ri_m | acc;
				fe_m = fe_m | (ck & !s);
				st = st | {30'h0, ck & !s, acc};
				if (acc) q.push_back(b);
				chk(32'(ri), 32'(ri_m));
				chk(32'(fe), 32'(fe_m));
				chk(32'(irq), 32'(|(st[1:0] & im)));
			end
			rreg(ufcaf_pkg::SER_CTRL_ADDR, v, ufcaf_pkg::RESP_OKAY);
			chk(v, {24'h0, fce ? fe_m : m[1], m[0], mpe, 2'h2, r8, 1'b0, ri_m});
			if (q.size() > 0) begin
				rreg(ufcaf_pkg::RX_DATA_ADDR, v, ufcaf_pkg::RESP_OKAY);
				chk(v, {24'h0, q[$]});
			end
			rreg(ufcaf_pkg::IRQ_STAT_ADDR, v, ufcaf_pkg::RESP_OKAY);
			chk(v, st);
			wreg(ufcaf_pkg::SER_CTRL_ADDR, {fce ? 1'b0 : m[1], sc[6:0]}, ufcaf_pkg::RESP_OKAY);
			wreg(ufcaf_pkg::IRQ_STAT_ADDR, 8'h03, ufcaf_pkg::RESP_OKAY);
			ri_m = 1'b0;
			fe_m = 1'b0;
			st = 32'h00000000;
			tick(2);
			chk(32'({fe, ri, irq}), 32'h0);
		end
		// second reset after the last iteration brings the address registers back to zero; only the mask is read back
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(2);
		rreg(ufcaf_pkg::NODE_MASK_ADDR, v, ufcaf_pkg::RESP_OKAY);
		chk(v, 32'h00000000);
		complete_run();
	end
endmodule
`default_nettype wire

// file: ufcaf_top.sv
// frame check and address filter with its AXI4-Lite register slave
// How it works
// - stop-bit checking runs only in modes 1 to 3 and only while framing_check_enable is set.
// - with checking on, each frame whose stop bit is low sets framing_error_flag.
// - framing_error_flag stays set until software or reset clears it; good frames leave it.
// - with checking on, receive_done_flag rises at the stop bit, not after the last data bit.
// - address filtering is active while multiproc_enable is set in modes 1 to 3.
// - with filtering, an address frame raises receive_done_flag only on a given or broadcast match.
// - in mode 1 with filtering the stop bit is the ninth bit and must be valid for a match.
// - in mode 0 multiproc_enable has no effect and nothing is filtered.
// - the given address ignores bits where node_address_mask is zero and compares the rest.
// - the broadcast address is node_address OR mask, its zero bits being don't-care.
// - reset clears node_address and node_address_mask, so any address is accepted.
// - bit 7 of serial_control_reg is framing_error_flag while framing_check_enable is set in any mode, else sm0_q, which is bit 1 of serial_mode.
// - multiproc_enable works in the 9-bit modes and optionally in mode 1.
`timescale 1ns/1ps
`default_nettype none
module ufcaf_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// axi4-lite write
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// from the receive shifter
	input  wire logic        rx_last_data,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_ninth_bit,
	input  wire logic        rx_stop_strobe,
	input  wire logic        rx_stop_level,
	// to the shifter and the system
	output logic [1:0]       serial_mode,
	output logic             rx_enable,
	output logic             tx_ninth_bit,
	output logic             double_baud,
	output logic             receive_done_flag,
	output logic             framing_error_flag,
	output logic             irq
);
	// write channel state
	logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [7:0]  wdata_q, wdata_d;
	logic        wstrb_q, wstrb_d;
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	// read channel state
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	// block registers
	logic        sm0_q, sm0_d, sm1_q, sm1_d, mpe_q, mpe_d, ren_q, ren_d;
	logic        tb8_q, tb8_d, rb8_q, rb8_d, ti_q, ti_d, ri_q, ri_d, fe_q, fe_d;
	logic        fce_q, fce_d, dbl_q, dbl_d;
	logic [7:0]  naddr_q, naddr_d, nmask_q, nmask_d, rxbuf_q, rxbuf_d;
	logic [7:0]  cap_byte_q, cap_byte_d;
	logic        cap_ninth_q, cap_ninth_d, pend_q, pend_d, irq_q, irq_d;
	logic [ufcaf_pkg::IS_W-1:0] stat_q, stat_d, imsk_q, imsk_d;
	// decoded terms
	logic        wr_fire, wr_en, async_m, mode1, check, filter, defer;
	logic        eval, addr_frame, given_hit, bcast_hit, accept, fe_event;
	logic [7:0]  ev_byte, bcast;
	logic        ev_ninth;
	logic        rd_hit;
	logic [7:0]  rd_val;

	// frame decision terms
	assign async_m  = {sm0_q, sm1_q} != 2'h0;
	assign mode1    = {sm0_q, sm1_q} == 2'h1;
	assign check    = fce_q && async_m;
	assign filter   = mpe_q && async_m;
	assign defer    = check || (filter && mode1);
	assign eval     = (rx_last_data && !defer) || (rx_stop_strobe && pend_q);
	assign ev_byte  = pend_q ? cap_byte_q : rx_byte;
	assign ev_ninth = pend_q ? cap_ninth_q : rx_ninth_bit;
	assign addr_frame = mode1 ? rx_stop_level : ev_ninth;
	assign given_hit  = ((ev_byte ^ naddr_q) & nmask_q) == 8'h00;
	assign bcast      = naddr_q | nmask_q;
	assign bcast_hit  = (bcast & ~ev_byte) == 8'h00;
	assign accept     = !filter || (addr_frame && (given_hit || bcast_hit));
	assign fe_event   = rx_stop_strobe && check && !rx_stop_level;
	assign wr_fire    = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_en      = wr_fire && wstrb_q;

	// read decode
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		unique case (s_axi_araddr)
			ufcaf_pkg::SER_CTRL_ADDR: begin
				rd_val = {fce_q ? fe_q : sm0_q, sm1_q, mpe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
			end
			ufcaf_pkg::PWR_CTRL_ADDR:  rd_val = {dbl_q, fce_q, 6'h00};
			ufcaf_pkg::NODE_ADDR_ADDR: rd_val = naddr_q;
			ufcaf_pkg::NODE_MASK_ADDR: rd_val = nmask_q;
			ufcaf_pkg::IRQ_STAT_ADDR:  rd_val = {6'h00, stat_q};
			ufcaf_pkg::IRQ_MASK_ADDR:  rd_val = {6'h00, imsk_q};
			ufcaf_pkg::RX_DATA_ADDR:   rd_val = rxbuf_q;
			default:                   rd_hit = 1'b0;
		endcase
	end

	// bus channel next state
	always_comb begin
		aw_hold_d = aw_hold_q;
		awaddr_d  = awaddr_q;
		w_hold_d  = w_hold_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (s_axi_awvalid && awready_q) begin
			aw_hold_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_hold_d = 1'b1;
			wdata_d  = s_axi_wdata[7:0];
			wstrb_d  = s_axi_wstrb[0];
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_fire) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			unique case (awaddr_q)
				ufcaf_pkg::SER_CTRL_ADDR, ufcaf_pkg::PWR_CTRL_ADDR,
				ufcaf_pkg::NODE_ADDR_ADDR, ufcaf_pkg::NODE_MASK_ADDR,
				ufcaf_pkg::IRQ_STAT_ADDR, ufcaf_pkg::IRQ_MASK_ADDR,
				ufcaf_pkg::RX_DATA_ADDR: bresp_d = ufcaf_pkg::RESP_OKAY;
				default:                 bresp_d = ufcaf_pkg::RESP_SLVERR;
			endcase
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d  = {24'h000000, rd_val};
			rresp_d  = rd_hit ? ufcaf_pkg::RESP_OKAY : ufcaf_pkg::RESP_SLVERR;
		end
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d  = !w_hold_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// bus channel registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= 12'h000;
			w_hold_q  <= 1'b0;
			wdata_q   <= 8'h00;
			wstrb_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= 2'h0;
		end else begin
			aw_hold_q <= aw_hold_d;
			awaddr_q  <= awaddr_d;
			w_hold_q  <= w_hold_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// block register next state: software write first, hardware set wins
	always_comb begin
		{sm0_d, sm1_d, mpe_d, ren_d, tb8_d, rb8_d, ti_d, ri_d} =
			{sm0_q, sm1_q, mpe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
		fe_d        = fe_q;
		fce_d       = fce_q;
		dbl_d       = dbl_q;
		naddr_d     = naddr_q;
		nmask_d     = nmask_q;
		rxbuf_d     = rxbuf_q;
		stat_d      = stat_q;
		imsk_d      = imsk_q;
		cap_byte_d  = cap_byte_q;
		cap_ninth_d = cap_ninth_q;
		pend_d      = pend_q;
		if (wr_en) begin
			unique case (awaddr_q)
				ufcaf_pkg::SER_CTRL_ADDR: begin
					if (fce_q) begin
						fe_d = wdata_q[ufcaf_pkg::SC_FE_SM0];
					end else begin
						sm0_d = wdata_q[ufcaf_pkg::SC_FE_SM0];
					end
					sm1_d = wdata_q[ufcaf_pkg::SC_SM1];
					mpe_d = wdata_q[ufcaf_pkg::SC_MPE];
					ren_d = wdata_q[ufcaf_pkg::SC_REN];
					tb8_d = wdata_q[ufcaf_pkg::SC_TB8];
					rb8_d = wdata_q[ufcaf_pkg::SC_RB8];
					ti_d  = wdata_q[ufcaf_pkg::SC_TI];
					ri_d  = wdata_q[ufcaf_pkg::SC_RI];
				end
				ufcaf_pkg::PWR_CTRL_ADDR: begin
					dbl_d = wdata_q[ufcaf_pkg::PC_DBL];
					fce_d = wdata_q[ufcaf_pkg::PC_FCE];
				end
				ufcaf_pkg::NODE_ADDR_ADDR: naddr_d = wdata_q;
				ufcaf_pkg::NODE_MASK_ADDR: nmask_d = wdata_q;
				ufcaf_pkg::IRQ_STAT_ADDR:  stat_d  = stat_q & ~wdata_q[ufcaf_pkg::IS_W-1:0];
				ufcaf_pkg::IRQ_MASK_ADDR:  imsk_d  = wdata_q[ufcaf_pkg::IS_W-1:0];
				default: ;
			endcase
		end
		// capture the frame at its last data bit; wait for the stop bit when deferred
		if (rx_last_data) begin
			cap_byte_d  = rx_byte;
			cap_ninth_d = rx_ninth_bit;
			pend_d      = defer;
		end else if (rx_stop_strobe) begin
			pend_d = 1'b0;
		end
		if (eval && accept) begin
			ri_d                         = 1'b1;
			rxbuf_d                      = ev_byte;
			stat_d[ufcaf_pkg::IS_RX]     = 1'b1;
			if (!mode1 && async_m) begin
				rb8_d = ev_ninth;
			end
		end
		// in mode 1 the stop level is only known at its strobe, so load it there
		if (mode1 && rx_stop_strobe) begin
			rb8_d = rx_stop_level;
		end
		if (fe_event) begin
			fe_d                     = 1'b1;
			stat_d[ufcaf_pkg::IS_FE] = 1'b1;
		end
		irq_d = |(stat_q & imsk_q);
	end

	// block registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			{sm0_q, sm1_q, mpe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <= ufcaf_pkg::SER_CTRL_RST;
			fe_q        <= 1'b0;
			fce_q       <= 1'b0;
			dbl_q       <= 1'b0;
			naddr_q     <= ufcaf_pkg::NODE_ADDR_RST;
			nmask_q     <= ufcaf_pkg::NODE_MASK_RST;
			rxbuf_q     <= 8'h00;
			stat_q      <= 2'h0;
			imsk_q      <= 2'h0;
			cap_byte_q  <= 8'h00;
			cap_ninth_q <= 1'b0;
			pend_q      <= 1'b0;
			irq_q       <= 1'b0;
		end else begin
			{sm0_q, sm1_q, mpe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <=
				{sm0_d, sm1_d, mpe_d, ren_d, tb8_d, rb8_d, ti_d, ri_d};
			fe_q        <= fe_d;
			fce_q       <= fce_d;
			dbl_q       <= dbl_d;
			naddr_q     <= naddr_d;
			nmask_q     <= nmask_d;
			rxbuf_q     <= rxbuf_d;
			stat_q      <= stat_d;
			imsk_q      <= imsk_d;
			cap_byte_q  <= cap_byte_d;
			cap_ninth_q <= cap_ninth_d;
			pend_q      <= pend_d;
			irq_q       <= irq_d;
		end
	end

	// outputs straight from flops
	assign s_axi_awready      = awready_q;
	assign s_axi_wready       = wready_q;
	assign s_axi_bvalid       = bvalid_q;
	assign s_axi_bresp        = bresp_q;
	assign s_axi_arready      = arready_q;
	assign s_axi_rvalid       = rvalid_q;
	assign s_axi_rdata        = rdata_q;
	assign s_axi_rresp        = rresp_q;
	assign serial_mode        = {sm0_q, sm1_q};
	assign rx_enable          = ren_q;
	assign tx_ninth_bit       = tb8_q;
	assign double_baud        = dbl_q;
	assign receive_done_flag  = ri_q;
	assign framing_error_flag = fe_q;
	assign irq                = irq_q;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_bad_stop;
		rx_stop_strobe && check && !rx_stop_level;
	endsequence
	sequence s_deferred_frame;
		rx_last_data && defer && !pend_q && !ri_q && !wr_fire;
	endsequence
	AST_FE_ONLY_ASYNC: assert property (rx_stop_strobe && !async_m && !fe_q && !wr_fire |=> !fe_q)
		else $error("framing error set outside the asynchronous modes");
	AST_FE_SET: assert property (s_bad_stop |=> fe_q && stat_q[ufcaf_pkg::IS_FE])
		else $error("bad stop bit did not set the framing error");
	AST_FE_STICKY: assert property (fe_q && !wr_fire |=> fe_q)
		else $error("framing error cleared without software");
	AST_RI_AT_STOP: assert property (s_deferred_frame |=> !ri_q && pend_q)
		else $error("receive done raised before the stop bit");
	AST_FILTER_REJECT: assert property (eval && filter && !accept && !ri_q && !wr_fire |=> !ri_q)
		else $error("rejected address frame raised receive done");
	AST_GIVEN_MATCH: assert property (eval && filter && !mode1 && ev_ninth && given_hit |=> ri_q)
		else $error("matching address frame missed");
	AST_MODE1_STOP: assert property (eval && filter && mode1 && !rx_stop_level && !ri_q && !wr_fire
		|=> !ri_q)
		else $error("mode 1 address frame accepted with bad stop bit");
	AST_MODE0_NOFILTER: assert property (rx_last_data && !async_m |=> ri_q && rxbuf_q == $past(rx_byte))
		else $error("mode 0 frame was filtered");
	AST_BCAST_MATCH: assert property (eval && filter && mode1 && rx_stop_level && (bcast & ~ev_byte) == 8'h00
		|=> ri_q)
		else $error("broadcast address frame missed");
	AST_RESET_ADDR: assert property ($past(rst_n) == 1'b0 |-> naddr_q == 8'h00 && nmask_q == 8'h00)
		else $error("address registers not cleared by reset");
	AST_IRQ_LEVEL: assert property ((stat_q & imsk_q) != 2'h0 |=> irq_q)
		else $error("unmasked status did not raise the interrupt");
endmodule
`default_nettype wire
